//--- include/msrd_pkg.sv
// Register map, field positions, reset values and types for the modem status / rx DMA block
package msrd_pkg;
    // Avalon word offsets (byte addresses)
    localparam int ADDR_W = 5;
    localparam logic [4:0] MSR_OFS = 5'h00;
    localparam logic [4:0] MCR_OFS = 5'h04;
    localparam logic [4:0] FCR_OFS = 5'h08;
    localparam logic [4:0] INT_STAT_OFS = 5'h0C;
    localparam logic [4:0] INT_CLR_OFS = 5'h10;
    localparam logic [4:0] INT_EN_OFS = 5'h14;
    // Field positions
    localparam int MSR_DELTA_BIT = 2;
    localparam int MSR_BELL_BIT = 6;
    localparam int MCR_SEND_BIT = 1;
    localparam int MCR_LOOP_BIT = 4;
    localparam int FCR_FIFO_BIT = 0;
    localparam int FCR_DMA_BIT = 3;
    localparam int INT_BELL_BIT = 0;
    localparam int INT_DMA_BIT = 1;
    localparam int INT_W = 2;
    // Reset values
    localparam logic [7:0] MCR_RST = 8'h00;
    localparam logic [7:0] FCR_RST = 8'h00;
    localparam logic [1:0] INT_EN_RST = 2'h0;
    localparam logic [1:0] INT_STAT_RST = 2'h0;
    // Bus handshake states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DONE = 2'b10
    } msrd_bus_t;
endpackage

//--- include/msrd_core_if.sv
// Signals shared between the top and its bell and rx DMA helpers
`timescale 1ns/1ps
interface msrd_core_if;
    logic bellIn;
    logic msrCapture;
    logic bellRise;
    logic deltaBellFlag;
    logic fifoEnableBit;
    logic dmaModeSelectBit;
    logic rxNotEmpty;
    logic rxTrigger;
    logic rxTimeout;
    logic rxReqN;
    modport ctrl (output bellIn, msrCapture, fifoEnableBit, dmaModeSelectBit,
        rxNotEmpty, rxTrigger, rxTimeout, input bellRise, deltaBellFlag, rxReqN);
    modport bell (input bellIn, msrCapture, output bellRise, deltaBellFlag);
    modport dma (input fifoEnableBit, dmaModeSelectBit, rxNotEmpty, rxTrigger,
        rxTimeout, output rxReqN);
endinterface

//--- rtl/msrd_bell_detect.sv
// Bell input rise detector and sticky change flag
`timescale 1ns/1ps
module msrd_bell_detect
    import msrd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    msrd_core_if.bell core
);
    logic bellPrev_q;
    logic primed_q;
    logic delta_q;

    // A rise needs one real prior sample; avoids a false edge just after reset
    assign core.bellRise = primed_q && core.bellIn && !bellPrev_q;

    // Previous level of the bell input
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            bellPrev_q <= 1'b0;
            primed_q <= 1'b0;
        end else begin
            bellPrev_q <= core.bellIn;
            primed_q <= 1'b1;
        end
    end

    // Change flag: a rise in the capture cycle wins over the read clear
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            delta_q <= 1'b0;
        end else if (core.bellRise) begin
            delta_q <= 1'b1;
        end else if (core.msrCapture) begin
            delta_q <= 1'b0;
        end
    end

    assign core.deltaBellFlag = delta_q;
endmodule

//--- rtl/msrd_rx_dma.sv
// Receive DMA request generator, mode 0 and mode 1
`timescale 1ns/1ps
module msrd_rx_dma
    import msrd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    msrd_core_if.dma core
);
    logic reqN_q;
    logic mode1;

    // Legacy non-FIFO operation only ever uses mode 0
    assign mode1 = core.fifoEnableBit && core.dmaModeSelectBit;

    // Active-low request; idle high after reset
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            reqN_q <= 1'b1;
        end else if (!mode1) begin
            reqN_q <= !core.rxNotEmpty;
        end else if (core.rxTrigger || core.rxTimeout) begin
            reqN_q <= 1'b0;
        end else if (!core.rxNotEmpty) begin
            reqN_q <= 1'b1;
        end
    end

    assign core.rxReqN = reqN_q;
endmodule

//--- rtl/msrd_top.sv
// Modem status bell input, send request output and receive DMA request with Avalon registers
//
// Behaviour
// - Modem status bit 6 shows the present bell input level.
// - Modem status bit 2 sets on a bell low-to-high rise since last read.
// - An enabled modem status interrupt fires on that bell rise.
// - Send request output is driven low while control bit 1 is set and loopback bit 4 is clear.
// - Send request is high on reset, in loopback, or with control bit 1 clear.
// - Send request never affects transmitter or receiver behaviour.
// - With FIFOs on, FIFO control bit 3 picks DMA mode 0 or mode 1.
// - Non-FIFO mode always uses DMA mode 0.
// - Mode 0 request goes low while any received character is held.
// - Mode 0 request returns high once no character remains.
// - Mode 1 request goes low on trigger level or time-out.
// - Mode 1 request stays low until empty, then goes high.
`timescale 1ns/1ps
module msrd_top
    import msrd_pkg::*;
#(
    parameter int DATA_W = 32
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [DATA_W-1:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [DATA_W-1:0] readdata,
    output logic waitrequest,
    input wire logic bellSignalIn,
    input wire logic rxNotEmpty,
    input wire logic rxTriggerHit,
    input wire logic rxTimeout,
    output logic sendRequestOut_n,
    output logic receiveDmaRequest_n,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    msrd_core_if core ();

    msrd_bus_t busState_q;
    logic waitrequest_q;
    logic [DATA_W-1:0] readdata_q;
    logic [DATA_W-1:0] readValue;
    logic [7:0] modemControl_q;
    logic [7:0] fifoControl_q;
    logic [INT_W-1:0] intStatus_q;
    logic [INT_W-1:0] intEnable_q;
    logic [INT_W-1:0] intEvents;
    logic [INT_W-1:0] intClear;
    logic sendReqN_q;
    logic irq_q;
    logic dmaReqPrev_q;
    logic capture;
    logic commit;

    // Address decode shared by reads, writes and the capture strobes
    function automatic logic addrHit(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] ofs);
        addrHit = (addr == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    msrd_bell_detect u_bell (
        .ref_clk(ref_clk),
        .reset(reset),
        .core(core.bell)
    );

    msrd_rx_dma u_dma (
        .ref_clk(ref_clk),
        .reset(reset),
        .core(core.dma)
    );

    // Inputs into the shared carrier
    assign core.bellIn = bellSignalIn;
    assign core.rxNotEmpty = rxNotEmpty;
    assign core.rxTrigger = rxTriggerHit;
    assign core.rxTimeout = rxTimeout;
    assign core.fifoEnableBit = fifoControl_q[FCR_FIFO_BIT];
    assign core.dmaModeSelectBit = fifoControl_q[FCR_DMA_BIT];
    // Status flag is sampled and cleared at the capture edge, never later
    assign core.msrCapture = capture && read && addrHit(address, MSR_OFS);

    ////////////////////////////////////////////////////////////////////////////
    // Avalon slave handshake

    // Capture edge sees the request; commit edge completes it
    assign capture = (busState_q == BUS_IDLE) && (read || write);
    assign commit = (busState_q == BUS_DONE) && (read || write);

    // One wait cycle per access, so read data is always a registered value
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            busState_q <= BUS_IDLE;
            waitrequest_q <= 1'b1;
        end else begin
            case (busState_q)
                BUS_IDLE: begin
                    if (read || write) begin
                        busState_q <= BUS_DONE;
                        waitrequest_q <= 1'b0;
                    end
                end
                BUS_DONE: begin
                    busState_q <= BUS_IDLE;
                    waitrequest_q <= 1'b1;
                end
                default: begin
                    busState_q <= BUS_IDLE;
                    waitrequest_q <= 1'b1;
                end
            endcase
        end
    end

    // Read mux; unmapped and write-only words read as zero
    always_comb begin
        readValue = '0;
        if (addrHit(address, MSR_OFS)) begin
            readValue[MSR_BELL_BIT] = bellSignalIn;
            readValue[MSR_DELTA_BIT] = core.deltaBellFlag;
        end else if (addrHit(address, MCR_OFS)) begin
            readValue[7:0] = modemControl_q;
        end else if (addrHit(address, FCR_OFS)) begin
            readValue[7:0] = fifoControl_q;
        end else if (addrHit(address, INT_STAT_OFS)) begin
            readValue[INT_W-1:0] = intStatus_q;
        end else if (addrHit(address, INT_EN_OFS)) begin
            readValue[INT_W-1:0] = intEnable_q;
        end
    end

    // Read data is held until the next read capture
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            readdata_q <= '0;
        end else if (capture && read) begin
            readdata_q <= readValue;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers

    // Modem control: send request and loopback; only lane 0 is backed
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            modemControl_q <= MCR_RST;
        end else if (commit && write && byteenable[0] && addrHit(address, MCR_OFS)) begin
            modemControl_q <= writedata[7:0];
        end
    end

    // FIFO control: FIFO enable and DMA mode select
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            fifoControl_q <= FCR_RST;
        end else if (commit && write && byteenable[0] && addrHit(address, FCR_OFS)) begin
            fifoControl_q <= writedata[7:0];
        end
    end

    // Interrupt enable
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            intEnable_q <= INT_EN_RST;
        end else if (commit && write && byteenable[0] && addrHit(address, INT_EN_OFS)) begin
            intEnable_q <= writedata[INT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Send request pin

    // Loopback keeps the modem line quiet; the pin feeds nothing internal
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sendReqN_q <= 1'b1;
        end else begin
            // Held active low in the flop so the pin needs no inverter after it
            sendReqN_q <= !(modemControl_q[MCR_SEND_BIT]
                && !modemControl_q[MCR_LOOP_BIT]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts

    // Previous DMA request level, for its falling edge
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dmaReqPrev_q <= 1'b1;
        end else begin
            dmaReqPrev_q <= core.rxReqN;
        end
    end

    // Events and software clear strobes
    always_comb begin
        intEvents = '0;
        intEvents[INT_BELL_BIT] = core.bellRise;
        intEvents[INT_DMA_BIT] = dmaReqPrev_q && !core.rxReqN;
        intClear = '0;
        if (commit && write && byteenable[0] && addrHit(address, INT_CLR_OFS)) begin
            intClear = writedata[INT_W-1:0];
        end
    end

    // Sticky status; an event in the clear cycle is kept
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            intStatus_q <= INT_STAT_RST;
        end else begin
            intStatus_q <= intEvents | (intStatus_q & ~intClear);
        end
    end

    // Level interrupt, one cycle behind the status register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(intStatus_q & intEnable_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign readdata = readdata_q;
    assign waitrequest = waitrequest_q;
    assign sendRequestOut_n = sendReqN_q;
    assign receiveDmaRequest_n = core.rxReqN;
    assign irq = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    logic mode1;
    logic fcrWrite;
    assign mode1 = core.fifoEnableBit && core.dmaModeSelectBit;
    assign fcrWrite = commit && write && addrHit(address, FCR_OFS);

    // Read of modem status captured this edge
    sequence msrReadCap;
        capture && read && addrHit(address, MSR_OFS);
    endsequence

    // Mode 1 request started by trigger or time-out
    sequence mode1Start;
        mode1 && !fcrWrite && (rxTriggerHit || rxTimeout);
    endsequence

    // Mode 1 request held while data remains
    sequence mode1Hold;
        mode1 && !fcrWrite && !receiveDmaRequest_n && rxNotEmpty
            && !rxTriggerHit && !rxTimeout;
    endsequence

    bell_level_a: assert property (@(posedge ref_clk) disable iff (reset)
        msrReadCap |=> readdata[MSR_BELL_BIT] == $past(bellSignalIn))
        else $error("bell level not reflected in modem status");

    delta_set_a: assert property (@(posedge ref_clk) disable iff (reset)
        core.bellRise |=> core.deltaBellFlag ##1 (core.deltaBellFlag || $past(capture)))
        else $error("bell change flag not set on rise");

    delta_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
        (msrReadCap and !core.bellRise) |=> !core.deltaBellFlag)
        else $error("bell change flag not cleared by status read");

    bell_irq_a: assert property (@(posedge ref_clk) disable iff (reset)
        (core.bellRise && intEnable_q[INT_BELL_BIT] && !(commit && write)) |-> ##2 irq)
        else $error("enabled bell rise gave no interrupt");

    send_active_a: assert property (@(posedge ref_clk) disable iff (reset)
        (modemControl_q[MCR_SEND_BIT] && !modemControl_q[MCR_LOOP_BIT]) |=> !sendRequestOut_n)
        else $error("send request not active while control bit set");

    send_inactive_a: assert property (@(posedge ref_clk) disable iff (reset)
        (!modemControl_q[MCR_SEND_BIT] || modemControl_q[MCR_LOOP_BIT]) |=> sendRequestOut_n)
        else $error("send request active in loopback or with bit clear");

    mode0_assert_a: assert property (@(posedge ref_clk) disable iff (reset)
        (!mode1 && !fcrWrite && rxNotEmpty) |=> !receiveDmaRequest_n)
        else $error("mode 0 request not active with data held");

    mode0_release_a: assert property (@(posedge ref_clk) disable iff (reset)
        (!mode1 && !fcrWrite && !rxNotEmpty) |=> receiveDmaRequest_n)
        else $error("mode 0 request not released when empty");

    legacy_mode_a: assert property (@(posedge ref_clk) disable iff (reset)
        (!core.fifoEnableBit && !fcrWrite && !rxNotEmpty && (rxTriggerHit || rxTimeout))
            |=> receiveDmaRequest_n)
        else $error("non-FIFO mode used mode 1 signalling");

    mode1_trigger_a: assert property (@(posedge ref_clk) disable iff (reset)
        mode1Start |=> !receiveDmaRequest_n)
        else $error("mode 1 request not active on trigger or time-out");

    mode1_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
        mode1Hold |=> !receiveDmaRequest_n)
        else $error("mode 1 request dropped before empty");

    mode1_release_a: assert property (@(posedge ref_clk) disable iff (reset)
        (mode1 && !fcrWrite && !rxNotEmpty && !rxTriggerHit && !rxTimeout)
            |=> receiveDmaRequest_n)
        else $error("mode 1 request not released when empty");

    mode_select_a: assert property (@(posedge ref_clk) disable iff (reset)
        (mode1Start ##1 (mode1 && rxNotEmpty && !fcrWrite)[*2]) |=> !receiveDmaRequest_n)
        else $error("FIFO mode select not honoured");

    // Flags and status stay set until their own clear; masked sources stay quiet
    delta_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
        (core.deltaBellFlag && !core.msrCapture) |=> core.deltaBellFlag)
        else $error("bell change flag lost before status read");

    status_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
        (intStatus_q[INT_BELL_BIT] && !(commit && write)) |=> intStatus_q[INT_BELL_BIT])
        else $error("bell interrupt status lost before clear");

    irq_mask_a: assert property (@(posedge ref_clk) disable iff (reset)
        (intEnable_q == '0) |=> !irq)
        else $error("interrupt raised with all sources masked");

    mode1_idle_a: assert property (@(posedge ref_clk) disable iff (reset)
        (mode1 && !fcrWrite && receiveDmaRequest_n && !rxTriggerHit && !rxTimeout)
            |=> receiveDmaRequest_n)
        else $error("mode 1 request active without trigger or time-out");

    bus_answer_a: assert property (@(posedge ref_clk) disable iff (reset)
        capture |=> !waitrequest ##1 waitrequest)
        else $error("bus answer not one wait cycle");
endmodule

//--- test/msrd_partner.sv
// Receive FIFO and DMA controller model at the far side of the rx DMA request
`timescale 1ns/1ps
module msrd_partner #(
    parameter int TRIG_LEVEL = 4
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic dmaReq_n,
    input wire logic burstMode,
    input wire logic dmaOn,
    input wire logic loadStrobe,
    input wire logic [4:0] loadCount,
    output logic rxNotEmpty,
    output logic rxTriggerHit,
    output logic [7:0] xferCount
);
    logic [4:0] level_q;
    logic [1:0] gap_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Single transfers leave a gap so the request can settle between them
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            level_q <= 5'h00;
            gap_q <= 2'h0;
            xferCount <= 8'h00;
        end else if (loadStrobe) begin
            level_q <= loadCount;
            xferCount <= 8'h00;
        end else if (dmaOn && !dmaReq_n && level_q != 5'h00 && gap_q == 2'h0) begin
            level_q <= level_q - 5'h01;
            xferCount <= xferCount + 8'h01;
            gap_q <= burstMode ? 2'h0 : 2'h2;
        end else if (gap_q != 2'h0) begin
            gap_q <= gap_q - 2'h1;
        end
    end

    // Occupancy flags seen by the block
    assign rxNotEmpty = (level_q != 5'h00);
    assign rxTriggerHit = (level_q >= 5'(TRIG_LEVEL));
endmodule

//--- test/msrd_top_tb_top.sv
// Self-checking bench for the modem status, send request and rx DMA block
`timescale 1ns/1ps
module msrd_top_tb_top;
    import msrd_pkg::*;
    logic ref_clk, reset, read, write, bellSignalIn, rxTimeout;
    logic [ADDR_W-1:0] address;
    logic [31:0] writedata, readdata, rdVal;
    logic [3:0] byteenable;
    logic waitrequest, rxNotEmpty, rxTriggerHit, sendRequestOut_n, receiveDmaRequest_n, irq;
    logic dmaOn, burstMode, loadStrobe;
    logic [4:0] loadCount;
    logic [7:0] xferCount;
    int err_count = 0;
    int total_checks = 0;

    msrd_top i_dut (.ref_clk(ref_clk), .reset(reset), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .bellSignalIn(bellSignalIn), .rxNotEmpty(rxNotEmpty),
        .rxTriggerHit(rxTriggerHit), .rxTimeout(rxTimeout),
        .sendRequestOut_n(sendRequestOut_n), .receiveDmaRequest_n(receiveDmaRequest_n),
        .irq(irq));

    msrd_partner #(.TRIG_LEVEL(4)) i_partner (.ref_clk(ref_clk), .reset(reset),
        .dmaReq_n(receiveDmaRequest_n), .burstMode(burstMode), .dmaOn(dmaOn),
        .loadStrobe(loadStrobe), .loadCount(loadCount), .rxNotEmpty(rxNotEmpty),
        .rxTriggerHit(rxTriggerHit), .xferCount(xferCount));

    // 10 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Closing report, the one exit of the run
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Register value comparison
    task automatic check_reg(string what, logic [31:0] exp, logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Pin level comparison
    task automatic check_pin(string what, logic exp, logic got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Holds the request until waitrequest is sampled low; a lost answer ends the run
    task automatic bus_wait();
        int k;
        for (k = 0; k < 20; k++) begin
            @(posedge ref_clk);
            if (waitrequest === 1'b0) break;
        end
        if (k == 20) begin
            err_count++;
            give_verdict();
        end
    endtask

    task automatic bus_write(logic [4:0] a, logic [7:0] d, logic [3:0] be = 4'hF);
        @(posedge ref_clk);
        write <= 1'b1;
        address <= a;
        writedata <= {24'h000000, d};
        byteenable <= be;
        bus_wait();
        write <= 1'b0;
    endtask

    task automatic bus_read(logic [4:0] a);
        @(posedge ref_clk);
        read <= 1'b1;
        address <= a;
        bus_wait();
        rdVal = readdata;
        read <= 1'b0;
    endtask

    task automatic read_check(string what, logic [4:0] a, logic [31:0] exp);
        bus_read(a);
        check_reg(what, exp, rdVal);
    endtask

    // Bounded wait for a level of the rx DMA request
    task automatic wait_dma(logic lvl);
        int k;
        for (k = 0; k < 60 && receiveDmaRequest_n !== lvl; k++) @(posedge ref_clk);
        if (k == 60) begin
            err_count++;
            give_verdict();
        end
    endtask

    task automatic load_fifo(logic [4:0] n);
        @(posedge ref_clk);
        loadStrobe <= 1'b1;
        loadCount <= n;
        @(posedge ref_clk);
        loadStrobe <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values and an unmapped place
    task automatic test_reset_values();
        check_pin("send request", 1'b1, sendRequestOut_n);
        check_pin("dma request", 1'b1, receiveDmaRequest_n);
        check_pin("irq", 1'b0, irq);
        read_check("mcr", MCR_OFS, 32'h00000000);
        read_check("fcr", FCR_OFS, 32'h00000000);
        read_check("int enable", INT_EN_OFS, 32'h00000000);
        bus_write(5'h18, 8'hFF);
        read_check("unmapped", 5'h18, 32'h00000000);
    endtask

    // Bell level, change flag and clear on read
    task automatic test_bell_flag();
        read_check("msr idle", MSR_OFS, 32'h00000000);
        bellSignalIn <= 1'b1;
        tick(4);
        read_check("msr rise", MSR_OFS, 32'h00000044);
        read_check("msr reread", MSR_OFS, 32'h00000040);
        bellSignalIn <= 1'b0;
        tick(4);
        read_check("msr low", MSR_OFS, 32'h00000000);
    endtask

    // Bell interrupt raised, cleared and masked
    task automatic test_bell_irq();
        bus_write(INT_EN_OFS, 8'h01);
        bellSignalIn <= 1'b1;
        tick(4);
        check_pin("irq on rise", 1'b1, irq);
        read_check("int status", INT_STAT_OFS, 32'h00000001);
        bus_write(INT_CLR_OFS, 8'h01);
        tick(2);
        check_pin("irq cleared", 1'b0, irq);
        bellSignalIn <= 1'b0;
        bus_write(INT_EN_OFS, 8'h00);
        tick(2);
        bellSignalIn <= 1'b1;
        tick(4);
        check_pin("irq masked", 1'b0, irq);
        read_check("int masked", INT_STAT_OFS, 32'h00000001);
        bus_write(INT_CLR_OFS, 8'h01);
        bellSignalIn <= 1'b0;
    endtask

    // Send request: control bit, loopback, lane enable and a reset in mid-run
    task automatic test_send_request();
        bus_write(MCR_OFS, 8'h02);
        tick(3);
        check_pin("send active", 1'b0, sendRequestOut_n);
        bus_write(MCR_OFS, 8'h12);
        tick(3);
        check_pin("send loopback", 1'b1, sendRequestOut_n);
        bus_write(MCR_OFS, 8'h00);
        bus_write(MCR_OFS, 8'h02, 4'hE);
        tick(3);
        check_pin("send cleared", 1'b1, sendRequestOut_n);
        bus_write(MCR_OFS, 8'h02);
        tick(3);
        reset <= 1'b1;
        tick(2);
        check_pin("send reset", 1'b1, sendRequestOut_n);
        reset <= 1'b0;
        tick(1);
        read_check("mcr reset", MCR_OFS, 32'h00000000);
    endtask

    // Mode 0 single transfers with the send request active
    task automatic test_mode0(logic [7:0] fifo_control_reg, logic [4:0] n);
        bus_write(MCR_OFS, 8'h02);
        bus_write(FCR_OFS, fifo_control_reg);
        rxTimeout <= 1'b1;
        tick(1);
        rxTimeout <= 1'b0;
        tick(1);
        check_pin("mode0 timeout empty", 1'b1, receiveDmaRequest_n);
        dmaOn <= 1'b0;
        burstMode <= 1'b0;
        load_fifo(n);
        tick(3);
        check_pin("mode0 active", 1'b0, receiveDmaRequest_n);
        dmaOn <= 1'b1;
        wait_dma(1'b1);
        check_reg("mode0 transfers", {27'h0, n}, {24'h0, xferCount});
        check_pin("mode0 empty", 1'b0, rxNotEmpty);
        dmaOn <= 1'b0;
    endtask

    // Mode 1 on time-out and on trigger level, with burst drain
    task automatic test_mode1();
        bus_write(FCR_OFS, 8'h09);
        burstMode <= 1'b1;
        load_fifo(5'h02);
        tick(5);
        check_pin("mode1 below trigger", 1'b1, receiveDmaRequest_n);
        rxTimeout <= 1'b1;
        tick(1);
        rxTimeout <= 1'b0;
        wait_dma(1'b0);
        tick(4);
        check_pin("mode1 timeout held", 1'b0, receiveDmaRequest_n);
        dmaOn <= 1'b1;
        wait_dma(1'b1);
        check_reg("mode1 timeout xfers", 32'h00000002, {24'h0, xferCount});
        dmaOn <= 1'b0;
        load_fifo(5'h05);
        wait_dma(1'b0);
        check_pin("mode1 trigger", 1'b0, receiveDmaRequest_n);
        dmaOn <= 1'b1;
        wait_dma(1'b1);
        check_reg("mode1 trigger xfers", 32'h00000005, {24'h0, xferCount});
        check_pin("mode1 empty", 1'b0, rxNotEmpty);
        dmaOn <= 1'b0;
    endtask

    // Rx DMA interrupt bit enabled, then cleared
    task automatic test_dma_irq();
        read_check("dma int status", INT_STAT_OFS, 32'h00000002);
        bus_write(INT_EN_OFS, 8'h02);
        tick(2);
        check_pin("dma irq", 1'b1, irq);
        bus_write(INT_CLR_OFS, 8'h02);
        tick(2);
        check_pin("dma irq clear", 1'b0, irq);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        reset = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 5'h00;
        writedata = 32'h00000000;
        byteenable = 4'hF;
        bellSignalIn = 1'b0;
        rxTimeout = 1'b0;
        dmaOn = 1'b0;
        burstMode = 1'b0;
        loadStrobe = 1'b0;
        loadCount = 5'h00;
        tick(6);
        reset <= 1'b0;
        tick(2);
        test_reset_values();
        test_bell_flag();
        test_bell_irq();
        test_send_request();
        test_mode0(8'h01, 5'h03);
        test_mode0(8'h00, 5'h01);
        test_mode0(8'h08, 5'h02);
        test_mode1();
        test_dma_irq();
        give_verdict();
    end
endmodule
